// ===== compat_mode_pkg.sv
// shared constants and types for the compatible mode select block
package compat_mode_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] OP_MODE_IDX     = 8'h03;
  localparam logic [7:0] OP_MODE_ADDR    = 8'h0c;
  localparam logic [7:0] LINK_STAT_ADDR  = 8'h20;

  // field positions of operating_mode_select
  localparam int MODE_LSB      = 0;
  localparam int MODE_MSB      = 2;
  localparam int MODE_DONE_BIT = 3;
  localparam int OVERRIDE_BIT  = 4;
  localparam int SPARE5_BIT    = 5;
  localparam int SPARE6_BIT    = 6;
  localparam int SPARE7_BIT    = 7;

  // field positions of link status
  localparam int STAT_COMPAT_BIT = 0;
  localparam int STAT_REFCLK_BIT = 1;
  localparam int STAT_FRAME_LSB  = 2;
  localparam int STAT_FRAME_MSB  = 7;

  // reset values
  localparam logic       OVERRIDE_RST = 1'b0;
  localparam logic [2:0] SPARE_RST    = 3'h0;

  // ****************************************************************
  // mode encodings
  // ****************************************************************
  localparam logic [2:0] MODE_CSI_SYNC   = 3'h0;
  localparam logic [2:0] MODE_RESERVED   = 3'h1;
  localparam logic [2:0] MODE_CSI_ASYNC  = 3'h2;
  localparam logic [2:0] MODE_DVP_EXTCLK = 3'h5;
  localparam logic [1:0] STRAP_CSI_SYNC  = 2'h1;
  localparam logic [1:0] STRAP_CSI_ASYNC = 2'h2;
  localparam logic [1:0] STRAP_DVP       = 2'h3;
  localparam logic [5:0] FRAME_STD_BITS  = 6'h28;
  localparam logic [5:0] FRAME_COMPAT_BITS = 6'h1c;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_NS         = 40;
  localparam int SETTLE_NS      = 640;
  localparam int SETTLE_CYC     = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int BACK_CH_KHZ    = 2500;
  localparam int BACK_CH_NS     = 1000000 / BACK_CH_KHZ;
  localparam int BACK_CH_CYC    = BACK_CH_NS / CLK_NS;
  localparam int REFCLK_WIN_NS  = 2560;
  localparam int REFCLK_WIN_CYC = REFCLK_WIN_NS / CLK_NS;

  typedef enum logic [1:0] {
    PWR_DOWN   = 2'b00,
    PWR_SETTLE = 2'b01,
    PWR_READY  = 2'b11
  } pwr_state_e;

  // members run msb first: frame bits in 7:2, seen in 1, compat in 0
  typedef struct packed {
    logic [5:0] frame_bits;
    logic       refclk_seen;
    logic       compat;
  } link_status_s;

endpackage

// ===== pin_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module pin_sync3 #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a bit moves only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          level[i] <= s3[i];
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== rate_strobe.sv
// free running strobe generator, one pulse every DIV cycles while enabled
`timescale 1ns/10ps
`default_nettype none

module rate_strobe #(
  parameter int DIV = 10
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic enable,
  output logic      tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count;

  generate
    if (DIV < 2) begin : g_bad_div
      $error("rate_strobe needs DIV of at least 2");
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (!enable) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      tick  <= (count == LAST);
      count <= (count == LAST) ? '0 : count + 1'b1;
    end
  end

endmodule
`default_nettype wire

// ===== serializer_compat_mode_select.sv
// serializer operating mode select: strap latch, override, apb registers
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - transmitter frames 40 bits in standard mode, 28 bits in compatible mode
// - a legacy parallel deserializer needs the 28-bit compatible mode
// - strap 3 selects compatible mode; straps 1 and 2 are not compatible
// - mode field bits 2:0 at offset 0x03 always shows the current mode
// - with override bit 4 clear the mode field is read-only strap value
// - strap is captured on each low-to-high edge of the power-down pin
// - strapped compatible mode reads back as 101
// - with bit 4 set the mode field is writable, 101 forces compatible
// - override bit resets to 0; 1 lets the register field rule
// - 12-bit high-freq: 10 or 12 data plus 2 sync at 37.5 to 75 MHz
// - compatible mode back channel runs at 2.5 MHz
// - bit 3 is a read-only flag set once the mode is stable and latched
// - mode codes: 000 sync, 010 clock-in, 101 compatible, 001 reserved
module serializer_compat_mode_select #(
  parameter int ADDR_W        = 8,
  parameter int SETTLE_CYCLES = compat_mode_pkg::SETTLE_CYC,
  parameter int BACK_CH_DIV   = compat_mode_pkg::BACK_CH_CYC,
  parameter int REFCLK_WINDOW = compat_mode_pkg::REFCLK_WIN_CYC
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              power_down_release_pin,
  input  wire logic [1:0]        mode_strap_pin,
  input  wire logic              reference_clock_input,
  output logic      [5:0]        frame_bits,
  output logic                   compat_mode_active,
  output logic                   ref_clock_required,
  output logic                   back_channel_tick,
  output logic                   mode_latched
);

  // ****************************************************************
  // parameter checks
  // ****************************************************************
  generate
    if (ADDR_W < 8) begin : g_bad_addr
      $error("ADDR_W must be at least 8");
    end
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255) begin : g_bad_settle
      $error("SETTLE_CYCLES must be 1 to 255");
    end
    if (REFCLK_WINDOW < 2 || REFCLK_WINDOW > 255) begin : g_bad_win
      $error("REFCLK_WINDOW must be 2 to 255");
    end
  endgenerate

  localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYCLES - 1);
  localparam logic [7:0] WIN_LAST    = 8'(REFCLK_WINDOW - 1);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [3:0] pins_sync;
  logic       release_level;
  logic [1:0] strap_level;
  logic       refclk_level;

  pin_sync3 #(
    .W (4)
  ) u_pins (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     ({reference_clock_input, mode_strap_pin,
               power_down_release_pin}),
    .level   (pins_sync)
  );

  assign release_level = pins_sync[0];
  assign strap_level  = pins_sync[2:1];
  assign refclk_level = pins_sync[3];

  logic release_prev;
  logic release_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      release_prev <= 1'b0;
    end else begin
      release_prev <= release_level;
    end
  end

  assign release_rise = release_level & ~release_prev;

  // ****************************************************************
  // strap decode and latch
  // ****************************************************************
  logic [2:0] strap_code;
  logic [2:0] strap_mode;

  // unknown strap levels fall back to the synchronous camera mode
  always_comb begin
    case (strap_level)
      compat_mode_pkg::STRAP_DVP:
        strap_code = compat_mode_pkg::MODE_DVP_EXTCLK;
      compat_mode_pkg::STRAP_CSI_ASYNC:
        strap_code = compat_mode_pkg::MODE_CSI_ASYNC;
      compat_mode_pkg::STRAP_CSI_SYNC:
        strap_code = compat_mode_pkg::MODE_CSI_SYNC;
      default:
        strap_code = compat_mode_pkg::MODE_CSI_SYNC;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_mode <= compat_mode_pkg::MODE_CSI_SYNC;
    end else if (release_rise) begin
      strap_mode <= strap_code;
    end
  end

  // ****************************************************************
  // power sequence and settle flag
  // ****************************************************************
  compat_mode_pkg::pwr_state_e state;
  compat_mode_pkg::pwr_state_e next_state;
  logic [7:0]                  settle_count;

  always_comb begin
    next_state = state;
    case (state)
      compat_mode_pkg::PWR_DOWN: begin
        if (release_rise) begin
          next_state = compat_mode_pkg::PWR_SETTLE;
        end
      end
      compat_mode_pkg::PWR_SETTLE: begin
        if (!release_level) begin
          next_state = compat_mode_pkg::PWR_DOWN;
        end else if (settle_count == SETTLE_LAST) begin
          next_state = compat_mode_pkg::PWR_READY;
        end
      end
      compat_mode_pkg::PWR_READY: begin
        if (!release_level) begin
          next_state = compat_mode_pkg::PWR_DOWN;
        end
      end
      default: next_state = compat_mode_pkg::PWR_DOWN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= compat_mode_pkg::PWR_DOWN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_count <= 8'h00;
    end else if (state != compat_mode_pkg::PWR_SETTLE) begin
      settle_count <= 8'h00;
    end else begin
      settle_count <= settle_count + 8'h01;
    end
  end

  // ****************************************************************
  // operating_mode_select register
  // ****************************************************************
  logic       wr_done;
  logic       sel_mode;
  logic       sel_stat;
  logic       override;
  logic [2:0] sw_mode;
  logic [2:0] spare;
  logic [2:0] cur_mode;
  logic       mode_done;
  logic       addr_high;

  // any address bit above the low byte lies outside the map
  assign addr_high = |(paddr >> 8);
  assign sel_mode  = ~addr_high
                     & (paddr[7:0] == compat_mode_pkg::OP_MODE_ADDR);
  assign sel_stat  = ~addr_high
                     & (paddr[7:0] == compat_mode_pkg::LINK_STAT_ADDR);
  assign wr_done  = psel & penable & pready & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      override <= compat_mode_pkg::OVERRIDE_RST;
      spare    <= compat_mode_pkg::SPARE_RST;
    end else if (wr_done && sel_mode) begin
      override <= pwdata[compat_mode_pkg::OVERRIDE_BIT];
      spare    <= {pwdata[compat_mode_pkg::SPARE7_BIT],
                   pwdata[compat_mode_pkg::SPARE6_BIT],
                   pwdata[compat_mode_pkg::SPARE5_BIT]};
    end
  end

  // the software copy follows the strap while override is clear, so
  // setting override keeps the running mode until software writes one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_mode <= compat_mode_pkg::MODE_CSI_SYNC;
    end else if (!override) begin
      sw_mode <= strap_mode;
    end else if (wr_done && sel_mode) begin
      sw_mode <= pwdata[compat_mode_pkg::MODE_MSB:
                        compat_mode_pkg::MODE_LSB];
    end
  end

  assign cur_mode = override ? sw_mode : strap_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_done <= 1'b0;
    end else begin
      mode_done <= (next_state == compat_mode_pkg::PWR_READY);
    end
  end

  // ****************************************************************
  // framing and back channel
  // ****************************************************************
  logic is_compat;
  logic bc_tick;

  assign is_compat = cur_mode == compat_mode_pkg::MODE_DVP_EXTCLK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_bits         <= compat_mode_pkg::FRAME_STD_BITS;
      compat_mode_active <= 1'b0;
      ref_clock_required <= 1'b0;
      mode_latched       <= 1'b0;
    end else begin
      frame_bits <= is_compat ? compat_mode_pkg::FRAME_COMPAT_BITS
                              : compat_mode_pkg::FRAME_STD_BITS;
      compat_mode_active <= is_compat;
      ref_clock_required <= is_compat;
      mode_latched       <= mode_done;
    end
  end

  // back channel timing only runs once the link side is powered up
  rate_strobe #(
    .DIV (BACK_CH_DIV)
  ) u_back_ch (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (is_compat & mode_done),
    .tick    (bc_tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      back_channel_tick <= 1'b0;
    end else begin
      back_channel_tick <= bc_tick & is_compat & mode_done;
    end
  end

  // ****************************************************************
  // reference clock activity monitor
  // ****************************************************************
  // the pin filter passes clocks up to a quarter of pclk only; a faster
  // reference clock reads as absent, so this is a presence hint only
  logic       refclk_prev;
  logic [7:0] idle_count;
  logic       refclk_seen;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refclk_prev <= 1'b0;
      idle_count  <= 8'h00;
      refclk_seen <= 1'b0;
    end else begin
      refclk_prev <= refclk_level;
      if (refclk_level != refclk_prev) begin
        idle_count  <= 8'h00;
        refclk_seen <= 1'b1;
      end else if (idle_count == WIN_LAST) begin
        refclk_seen <= 1'b0;
      end else begin
        idle_count <= idle_count + 8'h01;
      end
    end
  end

  // ****************************************************************
  // apb slave
  // ****************************************************************
  compat_mode_pkg::link_status_s stat;
  logic [7:0]                    mode_reg_val;

  assign stat.compat      = is_compat;
  assign stat.refclk_seen = refclk_seen;
  assign stat.frame_bits  = is_compat ? compat_mode_pkg::FRAME_COMPAT_BITS
                                      : compat_mode_pkg::FRAME_STD_BITS;

  always_comb begin
    mode_reg_val = 8'h00;
    mode_reg_val[compat_mode_pkg::MODE_MSB:
                 compat_mode_pkg::MODE_LSB] = cur_mode;
    mode_reg_val[compat_mode_pkg::MODE_DONE_BIT] = mode_done;
    mode_reg_val[compat_mode_pkg::OVERRIDE_BIT]  = override;
    mode_reg_val[compat_mode_pkg::SPARE5_BIT]    = spare[0];
    mode_reg_val[compat_mode_pkg::SPARE6_BIT]    = spare[1];
    mode_reg_val[compat_mode_pkg::SPARE7_BIT]    = spare[2];
  end

  // answer is prepared in the setup cycle so pready and prdata come
  // from flops; costs no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      pslverr <= ~(sel_mode | sel_stat);
      prdata  <= 32'h0000_0000;
      if (!pwrite) begin
        if (sel_mode) begin
          prdata <= {24'h00_0000, mode_reg_val};
        end else if (sel_stat) begin
          prdata <= {24'h00_0000, stat};
        end
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// ===== compat_mode_sva.sv
// port assertions for the serializer mode select block
`timescale 1ns/10ps
`default_nettype none
module compat_mode_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              power_down_release_pin,
  input wire logic [5:0]        frame_bits,
  input wire logic              compat_mode_active,
  input wire logic              ref_clock_required,
  input wire logic              back_channel_tick,
  input wire logic              mode_latched
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic unmapped;
  assign unmapped = (paddr != compat_mode_pkg::OP_MODE_ADDR)
                 && (paddr != compat_mode_pkg::LINK_STAT_ADDR);
  a_pready_answer: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside ready");
  a_slverr_unmapped: assert property (psel && !penable && unmapped
    |=> pslverr && pready) else $error("unmapped access not refused");
  a_frame_width: assert property (frame_bits == (compat_mode_active ?
    compat_mode_pkg::FRAME_COMPAT_BITS : compat_mode_pkg::FRAME_STD_BITS))
    else $error("frame width does not match mode");
  a_refclk_req: assert property (ref_clock_required == compat_mode_active)
    else $error("reference clock demand wrong");
  a_tick_gap: assert property (back_channel_tick |=> !back_channel_tick[*8])
    else $error("back channel ticks too close");
  a_tick_mode: assert property (back_channel_tick |-> compat_mode_active)
    else $error("back channel tick outside compatible mode");
  a_latch_rise: assert property ($rose(power_down_release_pin)
    |-> ##[4:40] mode_latched) else $error("mode not latched after release");
  a_latch_fall: assert property ($fell(power_down_release_pin)
    |-> ##[1:10] !mode_latched) else $error("latched flag kept after power down");
endmodule
bind serializer_compat_mode_select compat_mode_sva #(.ADDR_W(ADDR_W)) i_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .power_down_release_pin(power_down_release_pin), .frame_bits(frame_bits),
  .compat_mode_active(compat_mode_active),
  .ref_clock_required(ref_clock_required),
  .back_channel_tick(back_channel_tick), .mode_latched(mode_latched));
`default_nettype wire

// ===== far_end_model.sv
// board oscillator and legacy parallel deserializer seen from the link
`timescale 1ns/10ps
`default_nettype none
module far_end_model #(
  parameter logic [2:0] FAR_STRAP = 3'h6 // coax, twelve-bit high freq
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [5:0] frame_bits,
  input  wire logic       compat_mode_active,
  input  wire logic       ref_clock_required,
  input  wire logic       back_channel_tick,
  output logic            reference_clock_input,
  output logic [7:0]      tick_gap,
  output logic            format_ok
);
  // ****************************************************************
  // oscillator and link view
  // ****************************************************************
  logic [7:0] gap_cnt;
  logic       osc_phase;
  logic       output_enable_pin;
  logic       output_sleep_state_select;
  // oscillator fitted only for compatible mode, so idle detection is seen;
  // it runs at a quarter of pclk so the pin filter passes every edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_phase             <= 1'b0;
      reference_clock_input <= 1'b0;
    end else begin
      osc_phase             <= ~osc_phase;
      reference_clock_input <= ref_clock_required
                               & (reference_clock_input ^ osc_phase);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt  <= 8'h00;
      tick_gap <= 8'h00;
    end else if (back_channel_tick) begin
      tick_gap <= gap_cnt + 8'h01;
      gap_cnt  <= 8'h00;
    end else begin
      gap_cnt <= gap_cnt + 8'h01;
    end
  end
  // far end format_ok is live only with both gating pins high; the clock and tick_gap are not gated
  assign output_enable_pin         = 1'b1;
  assign output_sleep_state_select = 1'b1;
  // legacy receiver only frames 28-bit words on coax; strap 7 would also
  // need the source to pace its sync lines; lock does not depend on link activity
  assign format_ok = compat_mode_active
    && output_enable_pin && output_sleep_state_select
    && (FAR_STRAP == 3'h6 || FAR_STRAP == 3'h7)
    && (frame_bits == compat_mode_pkg::FRAME_COMPAT_BITS);
endmodule
`default_nettype wire

// ===== serializer_compat_mode_select_bench.sv
// self-checking bench for the serializer mode select block
`timescale 1ns/10ps
`default_nettype none
module serializer_compat_mode_select_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        power_down_release_pin = 1'b0;
  logic [1:0]  mode_strap_pin = 2'h0;
  logic        reference_clock_input;
  logic [5:0]  frame_bits;
  logic        compat_mode_active;
  logic        ref_clock_required;
  logic        back_channel_tick;
  logic        mode_latched;
  logic [7:0]  tick_gap;
  logic        format_ok;
  logic [31:0] rd;
  logic        err;
  int          num_errors = 0;
  int          comparisons = 0;
  // ****************************************************************
  // instances and helpers
  // ****************************************************************
  always #20 pclk = ~pclk;
  // short settle and idle window keep the run brief
  serializer_compat_mode_select #(.SETTLE_CYCLES(2), .REFCLK_WINDOW(4)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .power_down_release_pin(power_down_release_pin),
    .mode_strap_pin(mode_strap_pin),
    .reference_clock_input(reference_clock_input), .frame_bits(frame_bits),
    .compat_mode_active(compat_mode_active),
    .ref_clock_required(ref_clock_required),
    .back_channel_tick(back_channel_tick), .mode_latched(mode_latched));
  far_end_model i_far (
    .pclk(pclk), .presetn(presetn), .frame_bits(frame_bits),
    .compat_mode_active(compat_mode_active),
    .ref_clock_required(ref_clock_required),
    .back_channel_tick(back_channel_tick),
    .reference_clock_input(reference_clock_input), .tick_gap(tick_gap),
    .format_ok(format_ok));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
    check(err, e);
  endtask
  task wait_latched(input logic v);
    int n;
    n = 0;
    while (mode_latched !== v && n < 100) begin
      @(posedge pclk);
      n++;
    end
    check(mode_latched, v);
  endtask
  task strap_cycle(input logic [1:0] s);
    @(posedge pclk);
    power_down_release_pin <= 1'b0;
    repeat (20) @(posedge pclk);
    check(mode_latched, 1'b0);
    mode_strap_pin <= s;
    repeat (4) @(posedge pclk);
    power_down_release_pin <= 1'b1;
    wait_latched(1'b1);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_reset;
    rd_chk(8'h0c, 32'h00, 1'b0);
    rd_chk(8'h20, 32'ha0, 1'b0);
  endtask
  task t_straps;
    logic [2:0] code [4];
    code = '{3'h0, 3'h0, 3'h2, 3'h5};
    for (int i = 0; i < 4; i++) begin
      strap_cycle(i[1:0]);
      rd_chk(8'h0c, {29'h1, code[i]}, 1'b0);
      check(frame_bits, (i == 3) ? 6'h1c : 6'h28);
    end
    repeat (30) @(posedge pclk);
    rd_chk(8'h20, 32'h73, 1'b0);
    check(format_ok, 1'b1);
    check(tick_gap, 8'd10);
  endtask
  task t_ignore;
    mode_strap_pin <= 2'h1;
    apb(1'b1, 8'h0c, 32'h02);
    repeat (10) @(posedge pclk);
    rd_chk(8'h0c, 32'h0d, 1'b0);
    check(compat_mode_active, 1'b1);
  endtask
  task t_override;
    apb(1'b1, 8'h0c, 32'h10);
    rd_chk(8'h0c, 32'h1d, 1'b0);
    apb(1'b1, 8'h0c, 32'h12);
    rd_chk(8'h0c, 32'h1a, 1'b0);
    repeat (12) @(posedge pclk);
    rd_chk(8'h20, 32'ha0, 1'b0);
    check(format_ok, 1'b0);
    check(ref_clock_required, 1'b0);
    apb(1'b1, 8'h0c, 32'hf5);
    rd_chk(8'h0c, 32'hfd, 1'b0);
    check(frame_bits, 6'h1c);
    apb(1'b1, 8'h0c, 32'h00);
    rd_chk(8'h0c, 32'h0d, 1'b0);
  endtask
  task t_unmapped;
    rd_chk(8'h04, 32'h00, 1'b1);
    apb(1'b1, 8'h20, 32'hff);
    check(err, 1'b0);
    repeat (10) @(posedge pclk);
    rd_chk(8'h20, 32'h73, 1'b0);
  endtask
  task t_release;
    power_down_release_pin <= 1'b0;
    wait_latched(1'b0);
    rd_chk(8'h0c, 32'h05, 1'b0);
  endtask
  task final_report;
    $display("errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200us;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_straps();
    t_ignore();
    t_override();
    t_unmapped();
    t_release();
    final_report();
  end
endmodule
`default_nettype wire
